// >>> verilog/uabf_pkg.sv
package uabf_pkg;

	// Clock and baud reference figures
	localparam int CLK_MHZ       = 100;
	localparam int MASTER_MHZ    = 96;
	localparam int REF_DIV_X2    = 13;
	localparam int OVERSAMPLE    = 16;
	localparam int REF_INC_I     = MASTER_MHZ * 2;
	localparam int REF_MOD_I     = REF_DIV_X2 * CLK_MHZ;
	localparam int REF_ACC_W     = 12;
	localparam logic [REF_ACC_W-1:0] REF_INC = REF_ACC_W'(REF_INC_I);
	localparam logic [REF_ACC_W-1:0] REF_MOD = REF_ACC_W'(REF_MOD_I);
	localparam logic [3:0]  OS_LAST      = 4'(OVERSAMPLE - 1);

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_DIV_LO     = 16'hFFA7;
	localparam logic [15:0] IDX_DIV_HI     = 16'hFFA8;
	localparam logic [15:0] IDX_RESUME_CH  = 16'hFFA9;
	localparam logic [15:0] IDX_PAUSE_CH   = 16'hFFAA;
	localparam logic [15:0] IDX_IRQ_MASK   = 16'hFFAB;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'hFFAC;
	localparam logic [15:0] IDX_FLOW_CTRL  = 16'hFFAD;

	// Reset values
	localparam logic [7:0]  DIV_LO_RST = 8'h08;
	localparam logic [7:0]  DIV_HI_RST = 8'h00;
	localparam logic [7:0]  XCHAR_RST  = 8'h00;
	localparam logic [2:0]  MASK_RST   = 3'h0;
	localparam logic [2:0]  FCTL_RST   = 3'h0;
	localparam logic [15:0] ONE16      = 16'h0001;

	// Interrupt mask bits
	localparam int MASK_MODEM = 0;
	localparam int MASK_LINE  = 1;
	localparam int MASK_TXRX  = 2;
	localparam int MASK_W     = 3;

	// Interrupt status bits
	localparam int ST_MODEM = 0;
	localparam int ST_LINE  = 1;
	localparam int ST_TXRX  = 2;
	localparam int ST_XON   = 3;
	localparam int ST_XOFF  = 4;
	localparam int ST_W     = 5;

	// Flow control register bits
	localparam int FC_XON_IE  = 0;
	localparam int FC_XOFF_IE = 1;
	localparam int FC_SWFLOW  = 2;
	localparam int FC_W       = 3;
	localparam int FC_RESUME  = 3;
	localparam int FC_PAUSED  = 6;
	localparam int FC_HALTED  = 7;

	typedef enum logic [1:0] {FL_IDLE, FL_SEND_OFF, FL_PAUSED, FL_SEND_ON} uabf_flow_e;

	// Receive error pulses
	typedef struct packed {
		logic brk;
		logic frame;
		logic parity;
		logic overrun;
	} uabf_rx_err_s;

	// Flow control character offered to the transmitter
	typedef struct packed {
		logic       valid;
		logic [7:0] char_val;
	} uabf_flow_tx_s;

endpackage

// >>> verilog/uabf_core.sv
// Overview of operation
// - Baud divisor is divisor-high byte above divisor-low byte, sixteen bits.
// - Baud reference is the 96 MHz master clock divided by 6.5.
// - Bit rate is reference divided by sixteen times the divisor.
// - Divisor-low resets to 08h, selecting about 115200 bps.
// - Divisor-high resets to zero.
// - Received character equal to resume char interrupts when its enable is set.
// - Transmitted resume flow character is the resume register byte.
// - Received character equal to pause char halts DMA and may interrupt.
// - Transmitted pause flow character is the pause register byte.
// - Resume and pause registers are eight bits, read/write, reset zero.
// - Mask bit 0 enables the modem interrupt; resets to zero.
// - Mask bit 1 enables the line-status interrupt; resets to zero.
// - Divisors above those for 1200 bps are accepted for slower rates.
// - Software flow sends pause when buffer fills, resume when it empties.
// - Break, framing, parity or overrun halts DMA and raises line-status interrupt.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps

module uabf_core
	import uabf_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Receiver side events
	input  wire logic                rx_valid,
	input  wire logic [7:0]          rx_char,
	input  wire uabf_rx_err_s        rx_err,
	input  wire logic                modem_change,
	input  wire logic                tx_holding_empty,
	input  wire logic                rx_holding_full,
	input  wire logic                rx_buf_full,
	input  wire logic                rx_buf_empty,
	// Flow character to transmitter
	output uabf_flow_tx_s            flow_tx,
	input  wire logic                flow_tx_ready,
	// Baud and control outputs
	output logic [15:0]              baud_divisor,
	output logic                     baud_ref_tick,
	output logic                     sample_tick,
	output logic                     bit_tick,
	output logic                     dma_halt,
	output logic                     irq
);

	// Whole register state of the block
	typedef struct packed {
		// Software-visible registers
		logic [7:0]        div_lo;
		logic [7:0]        div_hi;
		logic [7:0]        resume_ch;
		logic [7:0]        pause_ch;
		logic [MASK_W-1:0] mask;
		logic [FC_W-1:0]   fctl;
		logic [ST_W-1:0]   status;
		logic              halt;
		// Baud generator
		logic [REF_ACC_W-1:0] ref_acc;
		logic [15:0]       sub_cnt;
		logic [3:0]        os_cnt;
		logic              ref_tick;
		logic              os_tick;
		logic              bit_tick;
		logic [15:0]       div_live;
		// Flow control and event history
		uabf_flow_e        flow;
		uabf_flow_tx_s     ftx;
		logic              txe_prev;
		logic              rxf_prev;
		// Bus answer and interrupt
		logic              pready;
		logic [31:0]       prdata;
		logic              pslverr;
		logic              irq;
	} uabf_state_s;

	uabf_state_s s_q;
	uabf_state_s s_d;

	// Refuse an address bus too narrow for the register map
	if (ADDR_W < 18) begin : g_addr_check
		$error("uabf_core: ADDR_W must be at least 18");
	end

	// Refuse an accumulator too narrow for the fractional step
	if (REF_MOD_I + REF_INC_I > (1 << REF_ACC_W)) begin : g_acc_check
		$error("uabf_core: REF_ACC_W too narrow for the reference step");
	end

	// Refuse a step asking for more than one tick per cycle
	if (REF_INC_I >= REF_MOD_I) begin : g_step_check
		$error("uabf_core: reference clock must be slower than clk");
	end

	// Sample counter wraps by itself, so it must span one bit
	if (OVERSAMPLE != (1 << $bits(OS_LAST))) begin : g_os_check
		$error("uabf_core: OVERSAMPLE must match the sample counter width");
	end

	// Register index to byte address match
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
		return a == ADDR_W'({idx, 2'b00});
	endfunction

	// Rising edge of a level input against its previous value
	function automatic logic rise(input logic now_lvl, input logic was_lvl);
		return now_lvl && !was_lvl;
	endfunction

	// Address lies inside the register map
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic ok;
		ok = 1'b0;
		if (hit(a, IDX_DIV_LO)) begin
			ok = 1'b1;
		end else if (hit(a, IDX_DIV_HI)) begin
			ok = 1'b1;
		end else if (hit(a, IDX_RESUME_CH)) begin
			ok = 1'b1;
		end else if (hit(a, IDX_PAUSE_CH)) begin
			ok = 1'b1;
		end else if (hit(a, IDX_IRQ_MASK)) begin
			ok = 1'b1;
		end else if (hit(a, IDX_IRQ_STATUS)) begin
			ok = 1'b1;
		end else if (hit(a, IDX_FLOW_CTRL)) begin
			ok = 1'b1;
		end
		return ok;
	endfunction

	// Read data for one address, narrow registers in the low bits
	function automatic logic [31:0] read_reg(input logic [ADDR_W-1:0] a,
			input uabf_state_s st);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (hit(a, IDX_DIV_LO)) begin
			r[7:0] = st.div_lo;
		end else if (hit(a, IDX_DIV_HI)) begin
			r[7:0] = st.div_hi;
		end else if (hit(a, IDX_RESUME_CH)) begin
			r[7:0] = st.resume_ch;
		end else if (hit(a, IDX_PAUSE_CH)) begin
			r[7:0] = st.pause_ch;
		end else if (hit(a, IDX_IRQ_MASK)) begin
			r[MASK_W-1:0] = st.mask;
		end else if (hit(a, IDX_IRQ_STATUS)) begin
			r[ST_W-1:0] = st.status;
		end else if (hit(a, IDX_FLOW_CTRL)) begin
			r[FC_W-1:0]  = st.fctl;
			r[FC_PAUSED] = (st.flow == FL_PAUSED) || (st.flow == FL_SEND_ON);
			r[FC_HALTED] = st.halt;
		end
		return r;
	endfunction

	// Next-state logic for the whole block
	always_comb begin
		logic              wr;
		logic              setup;
		logic [ST_W-1:0]   st_set;
		logic [ST_W-1:0]   st_clr;
		logic [ST_W-1:0]   irq_en;
		logic              halt_set;
		logic              resume;
		logic              line_err;
		logic [REF_ACC_W-1:0] acc_sum;
		logic [15:0]       div_new;

		// Defaults: hold state, no strobes
		wr       = 1'b0;
		setup    = 1'b0;
		st_set   = '0;
		st_clr   = '0;
		irq_en   = '0;
		halt_set = 1'b0;
		resume   = 1'b0;
		line_err = 1'b0;
		acc_sum  = '0;
		div_new  = '0;
		s_d      = s_q;

		// APB: setup cycle latches read data, access cycle completes
		setup     = psel && !penable;
		wr        = psel && penable && s_q.pready && pwrite;

		// Zero-wait answer, high in the access cycle only
		s_d.pready = setup;
		// Data and error captured while the address is stable
		if (setup) begin
			s_d.prdata  = pwrite ? 32'h0000_0000 : read_reg(paddr, s_q);
			s_d.pslverr = !mapped(paddr);
		end else begin
			s_d.pslverr = 1'b0;
		end

		// Register writes; reserved bits are dropped
		if (wr) begin
			if (hit(paddr, IDX_DIV_LO)) begin
				s_d.div_lo = pwdata[7:0];
			end else if (hit(paddr, IDX_DIV_HI)) begin
				s_d.div_hi = pwdata[7:0];
			end else if (hit(paddr, IDX_RESUME_CH)) begin
				s_d.resume_ch = pwdata[7:0];
			end else if (hit(paddr, IDX_PAUSE_CH)) begin
				s_d.pause_ch = pwdata[7:0];
			end else if (hit(paddr, IDX_IRQ_MASK)) begin
				s_d.mask = pwdata[MASK_W-1:0];
			end else if (hit(paddr, IDX_IRQ_STATUS)) begin
				st_clr = pwdata[ST_W-1:0];
			end else if (hit(paddr, IDX_FLOW_CTRL)) begin
				s_d.fctl = pwdata[FC_W-1:0];
				resume   = pwdata[FC_RESUME];
			end
		end

		// Baud reference: fractional step of 96 MHz / 6.5 from the system clock
		acc_sum = s_q.ref_acc + REF_INC;
		if (acc_sum >= REF_MOD) begin
			s_d.ref_acc  = acc_sum - REF_MOD;
			s_d.ref_tick = 1'b1;
		end else begin
			s_d.ref_acc  = acc_sum;
			s_d.ref_tick = 1'b0;
		end

		// Divisor counter, sixteen samples per bit
		div_new     = {s_q.div_hi, s_q.div_lo};

		// Sample and bit ticks are single-cycle pulses
		s_d.os_tick  = 1'b0;
		s_d.bit_tick = 1'b0;
		if (s_q.ref_tick) begin
			if (s_q.sub_cnt == 16'h0000) begin
				// Reload takes the current divisor, so a write lands cleanly
				s_d.sub_cnt  = div_new - ONE16;
				s_d.div_live = div_new;
				s_d.os_tick  = 1'b1;
				s_d.os_cnt   = s_q.os_cnt + 4'h1;
				s_d.bit_tick = (s_q.os_cnt == OS_LAST);
			end else begin
				s_d.sub_cnt = s_q.sub_cnt - ONE16;
			end
		end

		// Event capture into sticky status
		s_d.txe_prev = tx_holding_empty;
		s_d.rxf_prev = rx_holding_full;

		// Any receive error is a line-status event
		line_err     = rx_err.brk || rx_err.frame || rx_err.parity || rx_err.overrun;
		st_set[ST_MODEM] = modem_change;
		st_set[ST_LINE]  = line_err;
		st_set[ST_TXRX]  = rise(tx_holding_empty, s_q.txe_prev)
			|| rise(rx_holding_full, s_q.rxf_prev);
		st_set[ST_XON]   = rx_valid && (rx_char == s_q.resume_ch);
		st_set[ST_XOFF]  = rx_valid && (rx_char == s_q.pause_ch);

		// Set beats a clear in the same cycle, so no event is lost
		s_d.status = (s_q.status & ~st_clr) | st_set;

		// DMA halt on pause match or line error; resume write releases it
		halt_set = st_set[ST_XOFF] || line_err;
		s_d.halt = (s_q.halt && !resume) || halt_set;

		// Software receive flow control
		case (s_q.flow)
			// Idle: offer the pause character once the buffer fills
			FL_IDLE: begin
				if (s_q.fctl[FC_SWFLOW] && rx_buf_full) begin
					s_d.ftx.valid    = 1'b1;
					s_d.ftx.char_val = s_q.pause_ch;
					s_d.flow         = FL_SEND_OFF;
				end
			end
			FL_SEND_OFF: begin
				if (flow_tx_ready) begin
					s_d.ftx.valid = 1'b0;
					s_d.flow      = FL_PAUSED;
				end
			end
			// Paused: offer the resume character once the buffer drains
			FL_PAUSED: begin
				if (rx_buf_empty) begin
					s_d.ftx.valid    = 1'b1;
					s_d.ftx.char_val = s_q.resume_ch;
					s_d.flow         = FL_SEND_ON;
				end
			end
			FL_SEND_ON: begin
				if (flow_tx_ready) begin
					s_d.ftx.valid = 1'b0;
					s_d.flow      = FL_IDLE;
				end
			end
			default: begin
				s_d.ftx.valid = 1'b0;
				s_d.flow      = FL_IDLE;
			end
		endcase

		// Interrupt line: unmasked sticky status
		irq_en[ST_MODEM] = s_d.mask[MASK_MODEM];
		irq_en[ST_LINE]  = s_d.mask[MASK_LINE];
		irq_en[ST_TXRX]  = s_d.mask[MASK_TXRX];

		// Match interrupts enabled from the flow control register
		irq_en[ST_XON]   = s_d.fctl[FC_XON_IE];
		irq_en[ST_XOFF]  = s_d.fctl[FC_XOFF_IE];

		// Level output, high while any enabled status bit stands
		s_d.irq = |(s_d.status & irq_en);
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			// Software registers
			s_q.div_lo    <= DIV_LO_RST;
			s_q.div_hi    <= DIV_HI_RST;
			s_q.resume_ch <= XCHAR_RST;
			s_q.pause_ch  <= XCHAR_RST;
			s_q.mask      <= MASK_RST;
			s_q.fctl      <= FCTL_RST;
			s_q.status    <= '0;
			s_q.halt      <= 1'b0;
			// Baud generator
			s_q.ref_acc   <= '0;
			s_q.sub_cnt   <= '0;
			s_q.os_cnt    <= '0;
			s_q.ref_tick  <= 1'b0;
			s_q.os_tick   <= 1'b0;
			s_q.bit_tick  <= 1'b0;
			s_q.div_live  <= {DIV_HI_RST, DIV_LO_RST};
			// Flow control, edge history and bus answer
			s_q.flow      <= FL_IDLE;
			s_q.ftx       <= '0;
			s_q.txe_prev  <= 1'b1; // Transmitter idles empty, no false edge
			s_q.rxf_prev  <= 1'b0;
			s_q.pready    <= 1'b0;
			s_q.prdata    <= 32'h0000_0000;
			s_q.pslverr   <= 1'b0;
			s_q.irq       <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from state flops
	assign prdata        = s_q.prdata;
	assign pready        = s_q.pready;
	assign pslverr       = s_q.pslverr;

	// Flow character and baud generator
	assign flow_tx       = s_q.ftx;
	assign baud_divisor  = s_q.div_live;
	assign baud_ref_tick = s_q.ref_tick;
	assign sample_tick   = s_q.os_tick;
	assign bit_tick      = s_q.bit_tick;

	// Halt and interrupt levels
	assign dma_halt      = s_q.halt;
	assign irq           = s_q.irq;

endmodule

// >>> testbench/uabf_chk.sv
`timescale 1ns/1ps
module uabf_chk
	import uabf_pkg::*;
(
	// Clock and reset
	input wire logic          clk,
	input wire logic          reset,
	// Bus and event inputs
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic          rx_valid,
	input wire uabf_rx_err_s  rx_err,
	input wire logic          modem_change,
	input wire logic          tx_holding_empty,
	input wire logic          rx_holding_full,
	input wire logic          flow_tx_ready,
	// Block outputs
	input wire uabf_flow_tx_s flow_tx,
	input wire logic [15:0]   baud_divisor,
	input wire logic          baud_ref_tick,
	input wire logic          sample_tick,
	input wire logic          pready,
	input wire logic          dma_halt,
	input wire logic          irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// Quiet outputs after reset, zero-wait bus answer
	a_reset_state: assert property ($past(reset) |->
		baud_divisor == 16'h0008 && !irq && !dma_halt) else $error("bad reset state");
	a_apb_wait: assert property (psel && !penable |=> pready)
		else $error("no bus answer");
	// Halt and interrupt causes
	a_err_halt: assert property (|rx_err |=> dma_halt)
		else $error("error did not halt");
	a_irq_cause: assert property ($rose(irq) |-> $past(rx_valid || |rx_err ||
		modem_change || tx_holding_empty || rx_holding_full || psel && pwrite))
		else $error("irq without cause");
	// Baud reference spacing and divisor pipeline
	a_ref_gap: assert property (baud_ref_tick |=>
		(!baud_ref_tick) [*5] ##[1:2] baud_ref_tick) else $error("ref tick spacing");
	a_sample_ref: assert property (sample_tick |-> $past(baud_ref_tick))
		else $error("sample tick without ref");
	a_div_load: assert property ($changed(baud_divisor) |-> $past(baud_ref_tick))
		else $error("divisor loaded off reload");
	// Flow character offer
	a_flow_hold: assert property (flow_tx.valid && !flow_tx_ready |=>
		flow_tx.valid && $stable(flow_tx.char_val)) else $error("flow char dropped");
	a_flow_take: assert property (flow_tx.valid && flow_tx_ready |=> !flow_tx.valid)
		else $error("flow char repeated");
endmodule

bind uabf_core uabf_chk chk_u (.clk, .reset, .psel, .penable, .pwrite, .rx_valid, .rx_err,
	.modem_change, .tx_holding_empty, .rx_holding_full, .flow_tx_ready, .flow_tx,
	.baud_divisor, .baud_ref_tick, .sample_tick, .pready, .dma_halt, .irq);

// >>> testbench/uabf_peer.sv
`timescale 1ns/1ps
module uabf_peer
	import uabf_pkg::*;
(
	// Clock
	input  wire logic    clk,
	// Line-side traffic toward the block
	output logic         rx_valid,
	output logic [7:0]   rx_char,
	output uabf_rx_err_s rx_err,
	output logic         modem_change,
	output logic         flow_tx_ready
);
	logic       slow;
	logic [1:0] cnt_q;

	// Idle line at start
	initial begin
		slow = 1'b0;
		cnt_q = 2'h0;
		rx_valid = 1'b0;
		rx_char = 8'h5A;
		rx_err = '0;
		modem_change = 1'b0;
		flow_tx_ready = 1'b0;
	end

	// Transmitter takes a character every cycle, or one in four when slow
	always @(posedge clk) begin
		cnt_q <= cnt_q + 2'h1;
		flow_tx_ready <= !slow || cnt_q == 2'h3;
	end

	// One character, error or modem event; data scrambled afterwards
	task automatic pulse(input logic v, input logic [7:0] c, input logic [3:0] er, input logic m);
		@(posedge clk);
		rx_valid <= v;
		rx_char <= c;
		rx_err <= er;
		modem_change <= m;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_char <= ~c;
		rx_err <= '0;
		modem_change <= 1'b0;
	endtask
endmodule

// >>> testbench/uart_baud_flow_irq_mask_tb.sv
`timescale 1ns/1ps
module uart_baud_flow_irq_mask_tb
	import uabf_pkg::*;
;
	logic          clk, reset, psel, penable, pwrite, pready, pslverr, e;
	logic          rx_valid, modem_change, tx_holding_empty, rx_holding_full;
	logic          rx_buf_full, rx_buf_empty, flow_tx_ready, baud_ref_tick;
	logic          sample_tick, bit_tick, dma_halt, irq;
	logic [17:0]   paddr;
	logic [31:0]   pwdata, prdata, lfsr, mb, rd_q[$];
	logic [15:0]   baud_divisor, dv[4];
	logic [7:0]    rx_char, fl_q[$];
	uabf_rx_err_s  rx_err;
	uabf_flow_tx_s flow_tx;
	int            n_fail, compares, i, k, n;

	uabf_core dut_u (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rx_valid, .rx_char, .rx_err, .modem_change, .tx_holding_empty,
		.rx_holding_full, .rx_buf_full, .rx_buf_empty, .flow_tx, .flow_tx_ready,
		.baud_divisor, .baud_ref_tick, .sample_tick, .bit_tick, .dma_halt, .irq);
	uabf_peer peer_u (.clk, .rx_valid, .rx_char, .rx_err, .modem_change, .flow_tx_ready);

	// Clock
	always #5 clk = ~clk;

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic tmo;
		n_fail++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		test_done();
	endtask

	// One bus transfer, held until pready is seen high
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 9; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (pready !== 1'b1) tmo();
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] x);
		rd_q.push_back(x);
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic lvl(input logic [1:0] x);
		@(posedge clk);
		#1;
		check(32'({dma_halt, irq}), 32'(x));
	endtask

	task automatic drain;
		for (k = 0; k < 100 && fl_q.size() > 0; k++) @(posedge clk);
		if (fl_q.size() > 0) tmo();
	endtask

	// Reference ticks counted over one bit period
	task automatic bits(input logic [15:0] d);
		for (k = 0; k < 20000 && bit_tick !== 1'b1; k++) @(posedge clk);
		if (k == 20000) tmo();
		@(posedge clk);
		n = 0;
		for (k = 0; k < 20000 && bit_tick !== 1'b1; k++) begin
			n += int'(baud_ref_tick);
			@(posedge clk);
		end
		if (k == 20000) tmo();
		check(n, 32'(d) * 16);
	endtask

	// Results: read data and accepted flow characters
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			check(prdata, rd_q.size() > 0 ? rd_q.pop_front() : 'x);
		if (flow_tx.valid === 1'b1 && flow_tx_ready)
			check(32'(flow_tx.char_val), fl_q.size() > 0 ? 32'(fl_q.pop_front()) : 'x);
	end

	initial begin
		#900000;
		tmo();
	end

	initial begin
		{clk, psel, penable, pwrite, tx_holding_empty, rx_holding_full} = '0;
		{rx_buf_full, rx_buf_empty, paddr, pwdata, n_fail, compares} = '0;
		reset = 1'b1;
		lfsr = 32'h5d2d;
		dv = '{16'h0060, 16'h0008, 16'h0001, 16'h0400};
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd(IDX_DIV_LO, 32'h08);
		rd(IDX_DIV_HI, 32'h00);
		rd(IDX_RESUME_CH, 32'h00);
		rd(IDX_PAUSE_CH, 32'h00);
		rd(IDX_IRQ_MASK, 32'h00);
		for (i = 0; i < 2; i++) begin
			lfsr = nxt(lfsr);
			wr(IDX_RESUME_CH + 16'(i), lfsr);
			rd(IDX_RESUME_CH + 16'(i), {24'h0, lfsr[7:0]});
		end
		wr(IDX_IRQ_MASK, 32'hFF);
		rd(IDX_IRQ_MASK, 32'h07);
		rd(16'hFF00, 32'h0);
		check(32'(e), 32'h1);
		$display("registers done");
		wr(IDX_RESUME_CH, {24'h0, lfsr[7:0]});
		wr(IDX_PAUSE_CH, {24'h0, ~lfsr[7:0]});
		wr(IDX_IRQ_MASK, 32'h0);
		wr(IDX_FLOW_CTRL, 32'h03);
		peer_u.pulse(1'b1, ~lfsr[7:0], 4'h0, 1'b0);
		lvl(2'b11);
		rd(IDX_FLOW_CTRL, 32'h83);
		rd(IDX_IRQ_STATUS, 32'h10);
		wr(IDX_IRQ_STATUS, 32'h10);
		lvl(2'b10);
		wr(IDX_FLOW_CTRL, 32'h09);
		lvl(2'b00);
		peer_u.pulse(1'b1, lfsr[7:0], 4'h0, 1'b0);
		lvl(2'b01);
		wr(IDX_FLOW_CTRL, 32'h08);
		lvl(2'b00);
		peer_u.pulse(1'b1, ~lfsr[7:0], 4'h0, 1'b0);
		lvl(2'b10);
		rd(IDX_IRQ_STATUS, 32'h18);
		wr(IDX_IRQ_STATUS, 32'h18);
		wr(IDX_FLOW_CTRL, 32'h08);
		$display("match done");
		for (i = 0; i < 7; i++) begin
			mb = (i == 0) ? 32'h1 : (i < 5) ? 32'h2 : 32'h4;
			@(posedge clk);
			tx_holding_empty <= (i == 5);
			rx_holding_full <= (i == 6);
			peer_u.pulse(1'b0, 8'h00, (i > 0 && i < 5) ? 4'(1 << (i - 1)) : 4'h0, i == 0);
			lvl({i > 0 && i < 5, 1'b0});
			wr(IDX_IRQ_MASK, mb);
			lvl({i > 0 && i < 5, 1'b1});
			wr(IDX_IRQ_STATUS, mb);
			wr(IDX_FLOW_CTRL, 32'h08);
			wr(IDX_IRQ_MASK, 32'h0);
			lvl(2'b00);
		end
		$display("mask done");
		peer_u.slow = 1'b1;
		wr(IDX_FLOW_CTRL, 32'h04);
		fl_q.push_back(~lfsr[7:0]);
		@(posedge clk);
		rx_buf_full <= 1'b1;
		drain();
		rd(IDX_FLOW_CTRL, 32'h44);
		repeat (4) @(posedge clk);
		rx_buf_full <= 1'b0;
		fl_q.push_back(lfsr[7:0]);
		rx_buf_empty <= 1'b1;
		drain();
		@(posedge clk);
		rx_buf_empty <= 1'b0;
		$display("flow done");
		for (i = 0; i < 4; i++) begin
			wr(IDX_DIV_HI, 32'(dv[i][15:8]));
			wr(IDX_DIV_LO, 32'(dv[i][7:0]));
			rd(IDX_DIV_HI, 32'(dv[i][15:8]));
			for (k = 0; k < 20000 && baud_divisor !== dv[i]; k++) @(posedge clk);
			if (k == 20000) tmo();
			check(32'(baud_divisor), 32'(dv[i]));
			if (dv[i] < 16'h0100) bits(dv[i]);
		end
		$display("baud done");
		check(32'(rd_q.size() + fl_q.size()), 32'h0);
		test_done();
	end
endmodule
